// File: shared/blit_pkg.sv
/*
 * constants, field layouts and carrier types of the block-transfer engine.
 * assumes a 32-bit avalon-mm slave port with byte addresses, register
 * index = byte address / 4, and a 16-bit display-buffer port.
 */
package blit_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices (byte address is four times the index)
    localparam logic [9:0] REG_BASE = 10'h100;
    localparam logic [9:0] REG_CTRL = 10'h100;
    localparam logic [9:0] REG_FMT = 10'h101;
    localparam logic [9:0] REG_ROP = 10'h102;
    localparam logic [9:0] REG_OP = 10'h103;
    localparam logic [9:0] REG_SRC_LO = 10'h104;
    localparam logic [9:0] REG_SRC_MID = 10'h105;
    localparam logic [9:0] REG_SRC_HI = 10'h106;
    localparam logic [9:0] REG_DST_LO = 10'h108;
    localparam logic [9:0] REG_DST_MID = 10'h109;
    localparam logic [9:0] REG_DST_HI = 10'h10a;
    localparam logic [9:0] REG_STRIDE_LO = 10'h10c;
    localparam logic [9:0] REG_STRIDE_HI = 10'h10d;
    localparam logic [9:0] REG_WIDTH_LO = 10'h110;
    localparam logic [9:0] REG_WIDTH_HI = 10'h111;
    localparam logic [9:0] REG_HEIGHT_LO = 10'h112;
    localparam logic [9:0] REG_HEIGHT_HI = 10'h113;
    localparam logic [9:0] REG_BG_LO = 10'h114;
    localparam logic [9:0] REG_BG_HI = 10'h115;
    localparam logic [9:0] REG_DATA = 10'h120;
    localparam int REG_COUNT = 22;

    ////////////////////////////////////////////////////////////////////////
    // control / status bits
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_ACTIVE_BIT = 7;
    localparam int CTRL_NEMPTY_BIT = 6;
    localparam int CTRL_HALF_BIT = 5;
    localparam int CTRL_FULL_BIT = 4;
    localparam int CTRL_SRC_PACKED_BIT = 1;
    localparam int CTRL_DST_PACKED_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // codes and values
    localparam logic [7:0] OP_MOVE_NEG = 8'h03;
    localparam logic [7:0] OP_TWRITE = 8'h04;
    localparam logic [3:0] ROP_COPY = 4'hc;
    localparam logic [7:0] FMT_16BPP = 8'h01;
    localparam logic [7:0] FMT_8BPP = 8'h00;
    localparam logic [3:0] DATA_BE = 4'h3;
    localparam logic [23:0] PSIZE_16 = 24'h00_0002;
    localparam logic [23:0] PSIZE_8 = 24'h00_0001;
    localparam logic [1:0] BE_WORD = 2'h3;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_LOW = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // fifo geometry
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam logic [4:0] FIFO_FULL_CNT = 5'h10;
    localparam logic [4:0] FIFO_HALF_CNT = 5'h08;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic req;
        logic we;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
    } mem_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_SRC,
        ST_RD_DST,
        ST_WRITE,
        ST_TW_PIX,
        ST_TW_WR
    } state_t;

endpackage : blit_pkg

// File: sim/blit_engine_tb.sv
/* self-checking bench: registers, transparent write, backward move.
   assumes the display buffer model beside the engine. */
`timescale 1ns/100ps
module blit_engine_tb;
    import blit_pkg::*;
    logic clock_i, reset_i, avs_read, avs_write, ack, slow, wt;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, rdata, q;
    logic [15:0] mrd;
    mem_cmd_t cmd;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [15:0] px [4] = '{16'h1111, 16'h1234, 16'h2222, 16'h3333};
    blit_engine blit_engine_inst (.clock_i(clock_i), .reset_i(reset_i),
        .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(DATA_BE), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wt), .mem_cmd_o(cmd), .mem_ack_i(ack),
        .mem_rdata_i(mrd));
    disp_mem_model disp_mem_model_inst (.clock_i(clock_i),
        .reset_i(reset_i), .slow_i(slow), .cmd_i(cmd), .ack_o(ack),
        .rdata_o(mrd));
    ////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task acc(input logic w, input logic [9:0] i, input logic [15:0] d);
        int k;
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, d};
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (wt !== 1'b0 && k < 50);
        q = rdata;
        if (k >= 50) begin
            n_mismatch++;
            wrap_up();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock_i);
    endtask : acc
    task poll(input int b, input logic v);
        int k;
        k = 0;
        do begin
            acc(1'b0, REG_CTRL, 16'h0000);
            k++;
        end while (q[b] !== v && k < 200);
        cmp("ctrl active", {31'h0, v}, {31'h0, q[b]});
        if (k >= 200) wrap_up();
    endtask : poll
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        acc(1'b1, REG_FMT, 16'h0001);
        acc(1'b0, REG_FMT, 16'h0000);
        cmp("fmt", 32'h0000_0001, q);
        acc(1'b1, 10'h107, 16'h00ff);
        acc(1'b0, 10'h107, 16'h0000);
        cmp("unmapped", 32'h0000_0000, q);
    endtask : t_regs
    task t_twrite;
        for (int i = 8; i < 12; i++) disp_mem_model_inst.mem[i] = 16'hdead;
        acc(1'b1, REG_OP, {8'h00, OP_TWRITE});
        acc(1'b1, REG_BG_LO, 16'h0034);
        acc(1'b1, REG_BG_HI, 16'h0012);
        acc(1'b1, REG_DST_LO, 16'h0010);
        acc(1'b1, REG_WIDTH_LO, 16'h0001);
        acc(1'b1, REG_HEIGHT_LO, 16'h0001);
        acc(1'b1, REG_CTRL, 16'h0081);
        poll(7, 1'b1);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, REG_CTRL, 16'h0000);
            cmp("fifo full", 32'h0, {31'h0, q[4]});
            acc(1'b1, REG_DATA, px[i]);
        end
        poll(7, 1'b0);
        for (int i = 0; i < 4; i++)
            cmp("twrite pixel", {16'h0, i == 1 ? 16'hdead : px[i]},
                {16'h0, disp_mem_model_inst.mem[8 + i]});
    endtask : t_twrite
    task t_move;
        for (int i = 0; i < 8; i++) disp_mem_model_inst.mem[32 + i] = 16'ha0a0 + 16'(i);
        acc(1'b1, REG_OP, {8'h00, OP_MOVE_NEG});
        acc(1'b1, REG_ROP, 16'h000c);
        acc(1'b1, REG_SRC_LO, 16'h004a);
        acc(1'b1, REG_DST_LO, 16'h004c);
        acc(1'b1, REG_STRIDE_LO, 16'h0004);
        acc(1'b1, REG_CTRL, 16'h0080);
        poll(7, 1'b0);
        cmp("move 0", 32'h0000_a0a0, {16'h0, disp_mem_model_inst.mem[33]});
        cmp("move 1", 32'h0000_a0a1, {16'h0, disp_mem_model_inst.mem[34]});
        cmp("move 2", 32'h0000_a0a4, {16'h0, disp_mem_model_inst.mem[37]});
        cmp("move 3", 32'h0000_a0a5, {16'h0, disp_mem_model_inst.mem[38]});
    endtask : t_move
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    initial begin
        reset_i = 1'b1;
        {avs_read, avs_write, slow, avs_address, avs_writedata} = '0;
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        t_regs();
        t_twrite();
        slow <= 1'b1;
        t_move();
        wrap_up();
    end
endmodule : blit_engine_tb

// File: sim/disp_mem_model.sv
/* display buffer model: 256 words, optional late ack: two cycles late, one when req stays high between commands.
   assumes the engine holds mem_cmd_t until ack. */
`timescale 1ns/100ps
module disp_mem_model
    import blit_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire mem_cmd_t cmd_i,
    output logic ack_o,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [0:255];
    logic [1:0] wait_r;
    logic [7:0] idx;
    assign idx = cmd_i.addr[8:1];
    // no stale data outside the ack cycle
    assign rdata_o = ack_o ? mem[idx] : ~mem[idx];
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ack_o <= 1'b0;
            wait_r <= 2'h0;
        end else if (cmd_i.req && !ack_o && wait_r >= {slow_i, 1'b0}) begin
            ack_o <= 1'b1;
            wait_r <= 2'h0;
        end else begin
            ack_o <= 1'b0;
            wait_r <= cmd_i.req ? wait_r + 2'h1 : 2'h0;
        end
    end
    always @(posedge clock_i) begin
        if (cmd_i.req && cmd_i.we && ack_o && cmd_i.be[0]) begin
            mem[idx][7:0] <= cmd_i.wdata[7:0];
        end
        if (cmd_i.req && cmd_i.we && ack_o && cmd_i.be[1]) begin
            mem[idx][15:8] <= cmd_i.wdata[15:8];
        end
    end
endmodule : disp_mem_model

// File: src/blit_engine.sv
/*
 * block-transfer engine: backward move with raster op, transparent write.
 * assumes an avalon-mm master on the register port and a display buffer
 * that holds a request until it answers with mem_ack_i, read data valid
 * in the ack cycle.
 */
`timescale 1ns/100ps

//
// Contract
// - backward move starts at lower-right pixels and walks to upper-left
// - op 03h is the backward move, op 04h the transparent write
// - raster code 0Ch makes destination equal source
// - format 01h is two bytes per pixel, 00h one byte
// - line stride comes from the offset registers in 16-bit words
// - width and height registers hold pixels minus one, split low/high
// - packed-select zero means rectangle with stride, else lines back to back
// - writing 80h to control starts; bit 7 reads one while active
// - transparent write stays active until every pixel is taken and written
// - pixels equal to the key colour are not written
// - key is low background byte at 8 bpp, both bytes at 16 bpp
// - transparent write supports packed and rectangular destinations
// - at 16 bpp each data word is one pixel
// - at 8 bpp source bit 0 is the phase: one skips the first low byte
// - a line's last word may carry one pixel, in the low byte
// - at 8 bpp a line takes (width+2+phase)/2 words
// - only 16-bit data-window writes are accepted and counted
// - control bit 4 reports fifo full; host stops writing while set
// - fifo is 16 deep with not-empty, half-full and full flags
module blit_engine
    import blit_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output mem_cmd_t mem_cmd_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i
);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [4:0] rel(input logic [9:0] idx);
        logic [9:0] d;
        d = idx - REG_BASE;
        return d[4:0];
    endfunction : rel

    function automatic logic [15:0] pick(input logic [15:0] w,
                                         input logic a0, input logic f16);
        logic [15:0] r;
        r = f16 ? w : {8'h00, (a0 ? w[15:8] : w[7:0])};
        return r;
    endfunction : pick

    function automatic logic [15:0] spread(input logic [15:0] v,
                                           input logic f16);
        logic [15:0] r;
        r = f16 ? v : {v[7:0], v[7:0]};
        return r;
    endfunction : spread

    function automatic logic [1:0] lanes(input logic a0, input logic f16);
        logic [1:0] r;
        r = f16 ? BE_WORD : (a0 ? BE_HIGH : BE_LOW);
        return r;
    endfunction : lanes

    function automatic logic [15:0] rop(input logic [3:0] code,
                                        input logic [15:0] s,
                                        input logic [15:0] d);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = code[{s[i], d[i]}];
        end
        return r;
    endfunction : rop

    function automatic logic [23:0] adv_addr(input logic [23:0] cur,
        input logic [23:0] base, input logic packed_sel, input logic last_x,
        input logic neg, input logic [23:0] psz, input logic [23:0] strd);
        logic [23:0] r;
        if (last_x && !packed_sel) begin
            r = neg ? base - strd : base + strd;
        end else begin
            r = neg ? cur - psz : cur + psz;
        end
        return r;
    endfunction : adv_addr

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0] regs_r [REG_COUNT];
    logic [1:0] packed_r;
    logic active_r;
    logic ack_r;
    logic [31:0] rdata_r;
    state_t state_r;
    mem_cmd_t mem_r;
    logic [23:0] src_r, src_line_r, dst_r, dst_line_r;
    logic [15:0] x_r, y_r, src_pix_r;
    logic sel_r;
    logic [9:0] idx;
    logic in_regs, bus_req, bus_take, bus_wr, bus_rd_now;
    logic ctrl_wr, start_any, start_move, start_tw, data_wr;
    logic fmt16, is_move, is_key, last_x, last_y, finish;
    logic adv_move, adv_tw, adv, pop_cond;
    logic fifo_wr_ready, fifo_valid, fifo_pop;
    logic [15:0] fifo_word, width, height, bg, pix16;
    logic [4:0] fifo_count;
    logic [23:0] src_cfg, dst_cfg, psz, stride_b, src_nxt, dst_nxt;
    logic [7:0] ctrl_rd;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, answer at the second edge
    assign idx = avs_address_i[11:2];
    assign in_regs = (idx >= REG_BASE)
                     && (idx < REG_BASE + 10'(REG_COUNT));
    assign bus_req = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = bus_req && !ack_r;
    assign bus_take = bus_req && ack_r;
    assign bus_wr = bus_take && avs_write_i;
    assign bus_rd_now = avs_read_i && !ack_r;
    assign avs_readdata_o = rdata_r;
    assign ctrl_wr = bus_wr && (idx == REG_CTRL) && avs_byteenable_i[0];
    assign start_any = ctrl_wr && avs_writedata_i[CTRL_START_BIT] && !active_r;
    assign start_move = start_any && (regs_r[rel(REG_OP)] == OP_MOVE_NEG);
    assign start_tw = start_any && (regs_r[rel(REG_OP)] == OP_TWRITE);
    // only full 16-bit lane writes reach the fifo
    assign data_wr = bus_wr && (idx == REG_DATA) && active_r && !is_move
                     && (avs_byteenable_i == DATA_BE);
    assign ctrl_rd = {active_r, fifo_valid,
                      (fifo_count >= FIFO_HALF_CNT), !fifo_wr_ready,
                      2'h0, packed_r};

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= bus_req && !ack_r;
            if (bus_rd_now) begin
                if (idx == REG_CTRL) begin
                    rdata_r <= {24'h00_0000, ctrl_rd};
                end else if (in_regs) begin
                    rdata_r <= {24'h00_0000, regs_r[rel(idx)]};
                end else begin
                    rdata_r <= '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parameter registers, writable in any order
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_r[i] <= 8'h00;
            end
            packed_r <= 2'h0;
        end else if (bus_wr && avs_byteenable_i[0]) begin
            if (idx == REG_CTRL) begin
                packed_r <= avs_writedata_i[1:0];
            end else if (in_regs && idx != 10'h107 && idx != 10'h10b
                         && idx != 10'h10e && idx != 10'h10f) begin
                regs_r[rel(idx)] <= avs_writedata_i[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded configuration
    assign fmt16 = (regs_r[rel(REG_FMT)] == FMT_16BPP);
    assign psz = fmt16 ? PSIZE_16 : PSIZE_8;
    assign stride_b = {7'h00, regs_r[rel(REG_STRIDE_HI)],
                       regs_r[rel(REG_STRIDE_LO)], 1'b0};
    assign width = {regs_r[rel(REG_WIDTH_HI)],
                    regs_r[rel(REG_WIDTH_LO)]};
    assign height = {regs_r[rel(REG_HEIGHT_HI)],
                     regs_r[rel(REG_HEIGHT_LO)]};
    assign bg = {regs_r[rel(REG_BG_HI)], regs_r[rel(REG_BG_LO)]};
    assign src_cfg = {regs_r[rel(REG_SRC_HI)], regs_r[rel(REG_SRC_MID)],
                      regs_r[rel(REG_SRC_LO)]};
    assign dst_cfg = {regs_r[rel(REG_DST_HI)], regs_r[rel(REG_DST_MID)],
                      regs_r[rel(REG_DST_LO)]};
    assign is_move = (regs_r[rel(REG_OP)] == OP_MOVE_NEG);

    ////////////////////////////////////////////////////////////////////////
    // pixel fifo
    blit_fifo u_fifo (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .wr_valid_i(data_wr),
        .wr_data_i(avs_writedata_i[15:0]),
        .wr_ready_o(fifo_wr_ready),
        .rd_valid_o(fifo_valid),
        .rd_data_o(fifo_word),
        .rd_ready_i(fifo_pop),
        .count_o(fifo_count)
    );

    // a 16 bpp word is one pixel, 8 bpp picks the lane by sel
    assign pix16 = fmt16 ? fifo_word
                         : {8'h00, (sel_r ? fifo_word[15:8] : fifo_word[7:0])};
    assign is_key = fmt16 ? (pix16 == bg) : (pix16[7:0] == bg[7:0]);

    ////////////////////////////////////////////////////////////////////////
    // walk control
    assign last_x = (x_r == width);
    assign last_y = (y_r == height);
    assign adv_move = (state_r == ST_WRITE) && mem_ack_i;
    assign adv_tw = ((state_r == ST_TW_PIX) && fifo_valid && is_key)
                    || ((state_r == ST_TW_WR) && mem_ack_i);
    assign adv = adv_move || adv_tw;
    assign finish = adv && last_x && last_y;
    // word ends after high byte, or line ends on a low byte
    assign pop_cond = fmt16 || sel_r || last_x;
    assign fifo_pop = adv_tw && pop_cond;
    assign src_nxt = adv_addr(src_r, src_line_r, packed_r[1], last_x,
                              1'b1, psz, stride_b);
    assign dst_nxt = adv_addr(dst_r, dst_line_r, packed_r[0], last_x,
                              is_move, psz, stride_b);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            active_r <= 1'b0;
        end else if (start_move || start_tw) begin
            active_r <= 1'b1;
        end else if (finish) begin
            active_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            x_r <= '0;
            y_r <= '0;
            sel_r <= 1'b0;
        end else if (start_move || start_tw) begin
            x_r <= '0;
            y_r <= '0;
            sel_r <= !fmt16 && src_cfg[0];
        end else if (adv) begin
            x_r <= last_x ? 16'h0000 : x_r + 16'h0001;
            y_r <= last_x ? y_r + 16'h0001 : y_r;
            sel_r <= !fmt16 && (last_x ? src_cfg[0] : !sel_r);
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            src_r <= '0;
            src_line_r <= '0;
            dst_r <= '0;
            dst_line_r <= '0;
        end else if (start_move || start_tw) begin
            src_r <= src_cfg;
            src_line_r <= src_cfg;
            dst_r <= dst_cfg;
            dst_line_r <= dst_cfg;
        end else if (adv) begin
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            if (last_x) begin
                src_line_r <= src_nxt;
                dst_line_r <= dst_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // display-buffer sequencer
    assign mem_cmd_o = mem_r;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
            mem_r <= '0;
            src_pix_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_move) begin
                        mem_r.req <= 1'b1;
                        mem_r.we <= 1'b0;
                        mem_r.addr <= src_cfg;
                        state_r <= ST_RD_SRC;
                    end else if (start_tw) begin
                        state_r <= ST_TW_PIX;
                    end
                end
                ST_RD_SRC: begin
                    if (mem_ack_i) begin
                        src_pix_r <= pick(mem_rdata_i, src_r[0], fmt16);
                        mem_r.addr <= dst_r;
                        state_r <= ST_RD_DST;
                    end
                end
                ST_RD_DST: begin
                    if (mem_ack_i) begin
                        mem_r.we <= 1'b1;
                        mem_r.wdata <= spread(rop(regs_r[rel(REG_ROP)][3:0],
                            src_pix_r, pick(mem_rdata_i, dst_r[0], fmt16)),
                            fmt16);
                        mem_r.be <= lanes(dst_r[0], fmt16);
                        state_r <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (mem_ack_i) begin
                        mem_r.we <= 1'b0;
                        if (last_x && last_y) begin
                            mem_r.req <= 1'b0;
                            state_r <= ST_IDLE;
                        end else begin
                            mem_r.addr <= src_nxt;
                            state_r <= ST_RD_SRC;
                        end
                    end
                end
                ST_TW_PIX: begin
                    if (fifo_valid && !is_key) begin
                        mem_r.req <= 1'b1;
                        mem_r.we <= 1'b1;
                        mem_r.addr <= dst_r;
                        mem_r.wdata <= spread(pix16, fmt16);
                        mem_r.be <= lanes(dst_r[0], fmt16);
                        state_r <= ST_TW_WR;
                    end else if (finish) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_TW_WR: begin
                    if (mem_ack_i) begin
                        mem_r.req <= 1'b0;
                        mem_r.we <= 1'b0;
                        state_r <= (last_x && last_y) ? ST_IDLE : ST_TW_PIX;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_start_active: assert property (@(posedge clock_i) disable iff (reset_i)
        (start_move || start_tw) |=> active_r ##1 ctrl_rd[CTRL_ACTIVE_BIT])
        else $error("start did not raise active");

    a_other_op_idle: assert property (@(posedge clock_i) disable iff (reset_i)
        (start_any && !start_move && !start_tw) |=> !active_r)
        else $error("unsupported op started the engine");

    a_copy_rop: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_r == ST_RD_DST && mem_ack_i && fmt16
         && regs_r[rel(REG_ROP)][3:0] == ROP_COPY)
        |=> mem_r.wdata == $past(src_pix_r))
        else $error("copy raster op did not pass source");

    a_backward_step: assert property (@(posedge clock_i)
        disable iff (reset_i)
        (adv_move && !last_x) |=> mem_r.addr == $past(src_r) - $past(psz))
        else $error("backward move did not step by pixel size");

    a_start_corner: assert property (@(posedge clock_i) disable iff (reset_i)
        start_move |=> mem_r.req && !mem_r.we && mem_r.addr == $past(src_cfg))
        else $error("backward move did not start at source corner");

    a_key_skipped: assert property (@(posedge clock_i) disable iff (reset_i)
        (state_r == ST_TW_PIX && fifo_valid && is_key) |=> !mem_r.req)
        else $error("key colour pixel was written");

    a_done_written: assert property (@(posedge clock_i) disable iff (reset_i)
        $fell(active_r) |-> $past(mem_ack_i) || $past(adv_tw))
        else $error("active cleared without a final pixel");

    a_full_refuses: assert property (@(posedge clock_i) disable iff (reset_i)
        (fifo_count == FIFO_FULL_CNT) |-> !fifo_wr_ready
        && ctrl_rd[CTRL_FULL_BIT] && ctrl_rd[CTRL_HALF_BIT])
        else $error("full fifo not flagged");

    a_narrow_write: assert property (@(posedge clock_i) disable iff (reset_i)
        (avs_write_i && avs_byteenable_i != DATA_BE) |-> !data_wr)
        else $error("narrow write reached the fifo");

    a_byte_lane: assert property (@(posedge clock_i) disable iff (reset_i)
        (mem_r.req && mem_r.we && !fmt16)
        |-> mem_r.be == BE_HIGH || mem_r.be == BE_LOW)
        else $error("8 bpp write touched both lanes");

    a_bus_answer: assert property (@(posedge clock_i) disable iff (reset_i)
        $rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");

endmodule : blit_engine

// File: src/blit_fifo.sv
/*
 * 16-word deep, 16-bit wide pixel-word fifo with occupancy count.
 * assumes one clock; the filler checks wr_ready_o, the drainer rd_valid_o.
 */
`timescale 1ns/100ps

module blit_fifo
    import blit_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic wr_valid_i,
    input wire logic [15:0] wr_data_i,
    output logic wr_ready_o,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    input wire logic rd_ready_i,
    output logic [4:0] count_o
);

    logic [15:0] mem_r [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr_r;
    logic [FIFO_AW-1:0] rd_ptr_r;
    logic [4:0] count_r;
    logic push;
    logic pop;

    assign wr_ready_o = (count_r != FIFO_FULL_CNT);
    assign rd_valid_o = (count_r != 5'h00);
    assign rd_data_o = mem_r[rd_ptr_r];
    assign count_o = count_r;
    assign push = wr_valid_i && wr_ready_o;
    assign pop = rd_ready_i && rd_valid_o;

    ////////////////////////////////////////////////////////////////////////
    // storage
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= wr_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointers and count
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 4'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 4'h1;
            end
            if (push && !pop) begin
                count_r <= count_r + 5'h01;
            end else if (pop && !push) begin
                count_r <= count_r - 5'h01;
            end
        end
    end

endmodule : blit_fifo
